/* design/icm_defs.svh */
// Register map, field positions, reset values and timing counts
// Assumes inclusion by bare name from the design files only
`ifndef ICM_DEFS_SVH
`define ICM_DEFS_SVH

`define ICM_OFS_CON 8'h00
`define ICM_OFS_TAR 8'h04
`define ICM_OFS_SAR 8'h08
`define ICM_OFS_DATA 8'h10
`define ICM_OFS_HCNT 8'h14
`define ICM_OFS_MASK 8'h30
`define ICM_OFS_RAW 8'h34
`define ICM_OFS_EN 8'h6c
`define ICM_OFS_STAT 8'h70

`define ICM_CON_SLAVE 0
`define ICM_CON_RSEN 5
`define ICM_TAR_GC 10
`define ICM_TAR_COMMAND_SELECT_A 11
`define ICM_CMD_RESTART 10
`define ICM_CMD_STOP 9
`define ICM_CMD_DIR 8

`define ICM_EV_RX 2
`define ICM_EV_RDREQ 5
`define ICM_EV_ABORT 6
`define ICM_EV_STOP 9

`define ICM_HCNT_RST 16'h0028
`define ICM_HCNT_MIN 16'h0006
`define ICM_IDLE_MARGIN 16'h000a
`define ICM_SAR_RST 7'h55
`define ICM_LCNT_DEF 16'h0008

`endif

/* design/icm_pkg.sv */
// Types shared by the controller files
// Assumes the constants header supplies all numeric values
package icm_pkg;

  typedef enum logic [2:0] {
    M_IDLE = 3'h0,
    M_START = 3'h1,
    M_BITS = 3'h2,
    M_HOLD = 3'h3,
    M_STOP = 3'h4,
    M_RSTART = 3'h5
  } icm_mst_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_ADDR = 3'h1,
    S_AACK = 3'h2,
    S_RX = 3'h3,
    S_RACK = 3'h4,
    S_TXW = 3'h5,
    S_TX = 3'h6,
    S_TACK = 3'h7
  } icm_slv_t;

endpackage

/* design/icm_fifo.sv */
// Synchronous first-word-fall-through queue
// Assumes the caller never pops empty or pushes full on purpose
`timescale 1ns/1ps
module icm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Write side
  input wire logic push_i,
  input wire logic [WIDTH-1:0] din_i,
  // Read side
  input wire logic pop_i,
  output logic [WIDTH-1:0] dout_o,
  output logic empty_o,
  output logic full_o
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp, rp, next_wp, next_rp;
  logic [AW:0] cnt, next_cnt;
  logic do_push, do_pop;

  // Overflow and underflow are dropped rather than corrupting pointers
  always_comb begin
    do_push = push_i && !full_o;
    do_pop = pop_i && !empty_o;
    next_wp = do_push ? wp + 1'b1 : wp;
    next_rp = do_pop ? rp + 1'b1 : rp;
    next_cnt = cnt + {{AW{1'b0}}, do_push} - {{AW{1'b0}}, do_pop};
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
    end else begin
      wp <= next_wp;
      rp <= next_rp;
      cnt <= next_cnt;
    end
  end

  // Storage has no reset; contents are qualified by the count
  always_ff @(posedge core_clk_i) begin
    if (do_push) begin
      mem[wp] <= din_i;
    end
  end

  assign dout_o = mem[rp];
  assign empty_o = (cnt == '0);
  assign full_o = (cnt == DEPTH[AW:0]);
endmodule

/* design/icm_ctrl.sv */
// I2C controller: command queue, master and slave engines, SCL timing
// Assumes open-drain pads outside and a same-clock register master
`timescale 1ns/1ps
`include "icm_defs.svh"
module icm_ctrl #(
  parameter int TX_DEPTH = 16,
  parameter int RX_DEPTH = 16,
  parameter logic [15:0] LCNT = `ICM_LCNT_DEF
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Register port
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // Bus pins
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // Interrupt
  output logic irq_o
);
  logic en, slave, rsen, gc, command_select_a;
  logic [6:0] tar, sar;
  logic [15:0] hcnt;
  logic [9:0] mask, raw, next_raw, ev;
  logic scl_s1, scl_s2, scl_s3, sda_s1, sda_s2, sda_s3;
  logic [15:0] idle_cnt, next_idle;
  logic bus_idle;
  logic tx_push, tx_pop, tx_empty, tx_full, rx_push, rx_pop, rx_empty;
  logic rx_full;
  logic [10:0] tx_head;
  logic [7:0] rx_dout, rx_din;
  logic head_dir, head_stop, head_rst;

  // Clamp and threshold arithmetic shared by decode and idle logic
  function automatic logic [15:0] clamp_h(input logic [15:0] v);
    clamp_h = (v < `ICM_HCNT_MIN) ? `ICM_HCNT_MIN : v;
  endfunction
  function automatic logic [15:0] idle_thr(input logic [15:0] h);
    idle_thr = h + `ICM_IDLE_MARGIN;
  endfunction

  assign head_dir = tx_head[`ICM_CMD_DIR];
  assign head_stop = tx_head[`ICM_CMD_STOP];
  assign head_rst = tx_head[`ICM_CMD_RESTART];

  icm_fifo #(.WIDTH(11), .DEPTH(TX_DEPTH), .AW($clog2(TX_DEPTH))) u_txq (
    .core_clk_i(core_clk_i), .rst_i(rst_i),
    .push_i(tx_push), .din_i(wdata_i[10:0]),
    .pop_i(tx_pop), .dout_o(tx_head),
    .empty_o(tx_empty), .full_o(tx_full)
  );
  icm_fifo #(.WIDTH(8), .DEPTH(RX_DEPTH), .AW($clog2(RX_DEPTH))) u_rxq (
    .core_clk_i(core_clk_i), .rst_i(rst_i),
    .push_i(rx_push), .din_i(rx_din),
    .pop_i(rx_pop), .dout_o(rx_dout),
    .empty_o(rx_empty), .full_o(rx_full)
  );

  // Pin synchronisers; only the second stage and beyond are read
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      {scl_s1, scl_s2, scl_s3} <= 3'h7;
      {sda_s1, sda_s2, sda_s3} <= 3'h7;
    end else begin
      {scl_s1, scl_s2, scl_s3} <= {scl_i, scl_s1, scl_s2};
      {sda_s1, sda_s2, sda_s3} <= {sda_i, sda_s1, sda_s2};
    end
  end

  // Idle detector saturates so a long quiet bus stays idle; the compare
  // is inclusive so a high count lowered mid-count cannot wrap the counter
  always_comb begin
    next_idle = '0;
    if (scl_s2 && sda_s2) begin
      next_idle = (idle_cnt >= idle_thr(hcnt)) ? idle_cnt
                                               : idle_cnt + 16'h0001;
    end
  end
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      idle_cnt <= '0;
    end else begin
      idle_cnt <= next_idle;
    end
  end
  assign bus_idle = (idle_cnt >= idle_thr(hcnt));

  // Master engine state
  icm_pkg::icm_mst_t mst, next_mst;
  logic ph, next_ph, in_addr, next_in_addr, cur_dir, next_cur_dir;
  logic cur_stop, next_cur_stop, gc_sent, next_gc_sent;
  logic scl_drv, next_scl_drv, sda_drv, next_sda_drv;
  logic [15:0] tmr, next_tmr;
  logic [8:0] sh, next_sh;
  logic [3:0] bitn, next_bitn;
  logic byte_end, want_next, load_req, m_pop, m_push, m_abort, m_stop;

  assign byte_end = (mst == icm_pkg::M_BITS) && ph && scl_s2 &&
                    (tmr == '0) && (bitn == 4'h8);

  always_comb begin
    next_mst = mst;
    next_ph = ph;
    next_in_addr = in_addr;
    next_cur_dir = cur_dir;
    next_cur_stop = cur_stop;
    next_gc_sent = gc_sent;
    next_scl_drv = scl_drv;
    next_sda_drv = sda_drv;
    next_tmr = (tmr == '0) ? tmr : tmr - 16'h0001;
    next_sh = sh;
    next_bitn = bitn;
    want_next = 1'b0;
    load_req = 1'b0;
    m_pop = 1'b0;
    m_push = 1'b0;
    m_abort = 1'b0;
    m_stop = 1'b0;
    case (mst)
      icm_pkg::M_IDLE: begin
        next_scl_drv = 1'b0;
        next_sda_drv = 1'b0;
        if (en && !slave && !tx_empty && bus_idle) begin
          next_mst = icm_pkg::M_START;
          next_sda_drv = 1'b1;
          next_tmr = hcnt;
        end
      end
      icm_pkg::M_START: begin
        if (tmr == '0) begin
          next_scl_drv = 1'b1;
          next_in_addr = 1'b1;
          next_gc_sent = gc && command_select_a;
          next_sh = (gc && command_select_a) ? 9'h001 : {tar, head_dir, 1'b1};
          next_bitn = '0;
          next_ph = 1'b0;
          next_tmr = LCNT;
          next_mst = icm_pkg::M_BITS;
        end
      end
      icm_pkg::M_BITS: begin
        if (!ph) begin
          next_sda_drv = ~sh[8];
          if (tmr == '0) begin
            next_ph = 1'b1;
            next_scl_drv = 1'b0;
            next_tmr = hcnt;
          end
        end else if (!scl_s2) begin
          next_tmr = tmr; // Target stretching SCL; hold the count
        end else if (tmr == '0) begin
          next_sh = {sh[7:0], sda_s2};
          next_bitn = bitn + 4'h1;
          next_ph = 1'b0;
          next_scl_drv = 1'b1;
          next_tmr = LCNT;
          if (bitn == 4'h8) begin
            next_in_addr = 1'b0;
            if (in_addr) begin
              if (sda_s2) begin
                m_abort = 1'b1;
                next_mst = icm_pkg::M_STOP;
              end else begin
                load_req = 1'b1;
              end
            end else if (!cur_dir && sda_s2) begin
              m_abort = 1'b1;
              next_mst = icm_pkg::M_STOP;
            end else begin
              m_push = cur_dir;
              if (cur_stop) begin
                next_mst = icm_pkg::M_STOP;
              end else if (tx_empty) begin
                next_mst = icm_pkg::M_HOLD;
              end else begin
                want_next = 1'b1;
              end
            end
          end
        end
      end
      icm_pkg::M_HOLD: begin
        next_scl_drv = 1'b1;
        next_tmr = LCNT;
        if (!tx_empty) begin
          want_next = 1'b1;
        end
      end
      icm_pkg::M_RSTART, icm_pkg::M_STOP: begin
        if (!ph) begin
          next_sda_drv = (mst == icm_pkg::M_STOP);
          if (tmr == '0) begin
            next_ph = 1'b1;
            next_scl_drv = 1'b0;
            next_tmr = hcnt;
          end
        end else if (!scl_s2) begin
          next_tmr = tmr;
        end else if (tmr == '0) begin
          next_ph = 1'b0;
          next_sda_drv = (mst == icm_pkg::M_RSTART);
          m_stop = (mst == icm_pkg::M_STOP);
          next_tmr = hcnt;
          next_mst = (mst == icm_pkg::M_STOP) ? icm_pkg::M_IDLE
                                               : icm_pkg::M_START;
        end
      end
      default: next_mst = icm_pkg::M_IDLE;
    endcase
    // Choose how the next queued entry joins the transfer
    if (want_next) begin
      next_ph = 1'b0;
      if (head_rst || (head_dir != cur_dir)) begin
        next_mst = rsen ? icm_pkg::M_RSTART : icm_pkg::M_STOP;
      end else begin
        load_req = 1'b1;
      end
    end
    // Pop one entry and start its byte; flags live only in cur_*
    if (load_req) begin
      m_pop = 1'b1;
      next_cur_dir = head_dir;
      next_cur_stop = head_stop;
      next_bitn = '0;
      next_mst = icm_pkg::M_BITS;
      if (head_dir && gc_sent) begin
        m_abort = 1'b1;
        next_mst = icm_pkg::M_STOP;
      end else if (head_dir) begin
        next_sh = {8'hff, head_stop}; // NACK last byte
      end else begin
        next_sh = {tx_head[7:0], 1'b1};
      end
    end
    if (!en || slave) begin
      next_mst = icm_pkg::M_IDLE;
      next_scl_drv = 1'b0;
      next_sda_drv = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      mst <= icm_pkg::M_IDLE;
      {ph, in_addr, cur_dir, cur_stop, gc_sent} <= 5'h00;
      {scl_drv, sda_drv} <= 2'h0;
      tmr <= '0;
      sh <= '0;
      bitn <= '0;
    end else begin
      mst <= next_mst;
      {ph, in_addr, cur_dir, cur_stop} <=
        {next_ph, next_in_addr, next_cur_dir, next_cur_stop};
      {gc_sent, scl_drv, sda_drv} <= {next_gc_sent, next_scl_drv,
                                       next_sda_drv};
      tmr <= next_tmr;
      sh <= next_sh;
      bitn <= next_bitn;
    end
  end

  // Slave engine; moves on SCL edges seen through the synchroniser
  icm_pkg::icm_slv_t sst, next_sst;
  logic [7:0] ssh, next_ssh;
  logic [3:0] scnt, next_scnt;
  logic s_rd, next_s_rd, s_sda, next_s_sda, s_scl, next_s_scl;
  logic rise, fall, start_c, stop_c, s_pop, s_push, s_abort, s_req;

  assign rise = scl_s2 && !scl_s3;
  assign fall = !scl_s2 && scl_s3;
  assign start_c = scl_s2 && scl_s3 && sda_s3 && !sda_s2;
  assign stop_c = scl_s2 && scl_s3 && !sda_s3 && sda_s2;

  always_comb begin
    next_sst = sst;
    next_ssh = ssh;
    next_scnt = scnt;
    next_s_rd = s_rd;
    next_s_sda = s_sda;
    next_s_scl = 1'b0;
    {s_pop, s_push, s_abort, s_req} = 4'h0;
    if (rise && scnt != 4'h8) begin
      next_ssh = {ssh[6:0], sda_s2};
      next_scnt = scnt + 4'h1;
    end
    case (sst)
      icm_pkg::S_ADDR: begin
        if (fall && scnt == 4'h8) begin
          next_s_rd = ssh[0];
          next_s_sda = (ssh[7:1] == sar);
          next_sst = (ssh[7:1] == sar) ? icm_pkg::S_AACK : icm_pkg::S_IDLE;
        end
      end
      icm_pkg::S_AACK, icm_pkg::S_RACK: begin
        if (fall) begin
          next_s_sda = 1'b0;
          next_scnt = '0;
          next_sst = s_rd ? icm_pkg::S_TXW : icm_pkg::S_RX;
          s_req = s_rd;
        end
      end
      icm_pkg::S_RX: begin
        if (fall && scnt == 4'h8) begin
          s_push = 1'b1; // Direction bit plays no part here
          next_s_sda = 1'b1;
          next_sst = icm_pkg::S_RACK;
        end
      end
      icm_pkg::S_TXW: begin
        next_s_scl = 1'b1; // Stretch until software supplies a byte
        if (!tx_empty) begin
          s_pop = 1'b1;
          if (head_dir) begin
            s_abort = 1'b1;
          end else begin
            next_s_scl = 1'b0;
            next_s_sda = ~tx_head[7];
            next_ssh = {tx_head[6:0], 1'b0};
            next_scnt = 4'h1;
            next_sst = icm_pkg::S_TX;
          end
        end
      end
      icm_pkg::S_TX: begin
        if (fall) begin
          next_s_sda = (scnt == 4'h8) ? 1'b0 : ~ssh[7];
          next_ssh = {ssh[6:0], 1'b0};
          next_scnt = scnt + 4'h1;
          next_sst = (scnt == 4'h8) ? icm_pkg::S_TACK : icm_pkg::S_TX;
        end
      end
      icm_pkg::S_TACK: begin
        if (rise && sda_s2) begin
          next_sst = icm_pkg::S_IDLE;
        end else if (fall) begin
          next_sst = icm_pkg::S_TXW;
          s_req = 1'b1;
        end
      end
      default: next_sst = icm_pkg::S_IDLE;
    endcase
    if (start_c) begin
      next_sst = icm_pkg::S_ADDR;
      next_scnt = '0;
      next_s_sda = 1'b0;
    end else if (stop_c || !en || !slave) begin
      next_sst = icm_pkg::S_IDLE;
      next_s_sda = 1'b0;
      next_s_scl = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      sst <= icm_pkg::S_IDLE;
      ssh <= '0;
      scnt <= '0;
      {s_rd, s_sda, s_scl} <= 3'h0;
    end else begin
      sst <= next_sst;
      ssh <= next_ssh;
      scnt <= next_scnt;
      {s_rd, s_sda, s_scl} <= {next_s_rd, next_s_sda, next_s_scl};
    end
  end

  // Queue traffic from the register port and both engines
  assign tx_push = wr_i && (addr_i == `ICM_OFS_DATA);
  assign tx_pop = m_pop || s_pop;
  assign rx_push = m_push || s_push;
  assign rx_din = m_push ? sh[7:0] : ssh; // Ack bit not yet shifted in
  assign rx_pop = rd_i && (addr_i == `ICM_OFS_DATA);

  // Event collection; a set in the clearing cycle survives
  always_comb begin
    ev = '0;
    ev[`ICM_EV_RX] = rx_push;
    ev[`ICM_EV_RDREQ] = s_req;
    ev[`ICM_EV_ABORT] = m_abort || s_abort;
    ev[`ICM_EV_STOP] = m_stop || (stop_c && sst != icm_pkg::S_IDLE);
    next_raw = ((rd_i && addr_i == `ICM_OFS_RAW) ? '0 : raw) | ev;
  end

  // Register file; enable gates the timing register
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      {en, slave, rsen, gc, command_select_a} <= 5'h00;
      tar <= '0;
      sar <= `ICM_SAR_RST;
      hcnt <= `ICM_HCNT_RST;
      mask <= '0;
      raw <= '0;
      rdata_o <= '0;
    end else begin
      raw <= next_raw;
      if (wr_i) begin
        if (addr_i == `ICM_OFS_EN) begin
          en <= wdata_i[0];
        end else if (addr_i == `ICM_OFS_CON && !en) begin
          slave <= wdata_i[`ICM_CON_SLAVE];
          rsen <= wdata_i[`ICM_CON_RSEN];
        end else if (addr_i == `ICM_OFS_TAR && !en) begin
          tar <= wdata_i[6:0];
          gc <= wdata_i[`ICM_TAR_GC];
          command_select_a <= wdata_i[`ICM_TAR_COMMAND_SELECT_A];
        end else if (addr_i == `ICM_OFS_SAR && !en) begin
          sar <= wdata_i[6:0];
        end else if (addr_i == `ICM_OFS_HCNT && !en) begin
          hcnt <= clamp_h(wdata_i[15:0]);
        end else if (addr_i == `ICM_OFS_MASK) begin
          mask <= wdata_i[9:0];
        end
      end
      rdata_o <= '0;
      if (rd_i) begin
        if (addr_i == `ICM_OFS_DATA) begin
          rdata_o <= {24'h000000, rx_dout};
        end else if (addr_i == `ICM_OFS_HCNT) begin
          rdata_o <= {16'h0000, hcnt};
        end else if (addr_i == `ICM_OFS_CON) begin
          rdata_o <= {26'h0000000, rsen, 4'h0, slave};
        end else if (addr_i == `ICM_OFS_TAR) begin
          rdata_o <= {20'h00000, command_select_a, gc, 3'h0, tar};
        end else if (addr_i == `ICM_OFS_SAR) begin
          rdata_o <= {25'h0000000, sar};
        end else if (addr_i == `ICM_OFS_MASK) begin
          rdata_o <= {22'h000000, mask};
        end else if (addr_i == `ICM_OFS_RAW) begin
          rdata_o <= {22'h000000, raw};
        end else if (addr_i == `ICM_OFS_EN) begin
          rdata_o <= {31'h00000000, en};
        end else if (addr_i == `ICM_OFS_STAT) begin
          rdata_o <= {26'h0000000, bus_idle, rx_full, !rx_empty,
                      tx_full, tx_empty, (mst != icm_pkg::M_IDLE)};
        end
      end
    end
  end

  assign irq_o = |(raw & mask);
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe_o = scl_drv || s_scl;
  assign sda_oe_o = sda_drv || s_sda;

  property p_clamp;
    @(posedge core_clk_i) disable iff (rst_i)
    (wr_i && addr_i == `ICM_OFS_HCNT && !en &&
     wdata_i[15:0] < `ICM_HCNT_MIN) |=> (hcnt == 16'h0006);
  endproperty
  a_clamp: assert property (p_clamp) else $error("hcnt not clamped");
  property p_lock;
    @(posedge core_clk_i) disable iff (rst_i)
    (wr_i && addr_i == `ICM_OFS_HCNT && en) |=> $stable(hcnt);
  endproperty
  a_lock: assert property (p_lock) else $error("hcnt changed");
  property p_idle;
    @(posedge core_clk_i) disable iff (rst_i)
    !(scl_s2 && sda_s2) |=> !bus_idle ##0 (idle_cnt == 16'h0000);
  endproperty
  a_idle: assert property (p_idle) else $error("idle kept");
  property p_hold;
    @(posedge core_clk_i) disable iff (rst_i)
    (mst == icm_pkg::M_HOLD) |-> scl_oe_o;
  endproperty
  a_hold: assert property (p_hold) else $error("scl freed");
  property p_stall;
    @(posedge core_clk_i) disable iff (rst_i)
    (byte_end && !in_addr && !cur_stop && tx_empty && en && !slave &&
     !(!cur_dir && sda_s2)) |=> (mst == icm_pkg::M_HOLD);
  endproperty
  a_stall: assert property (p_stall) else $error("no stall");
  property p_stop;
    @(posedge core_clk_i) disable iff (rst_i)
    (byte_end && !in_addr && cur_stop && en && !slave)
      |=> (mst == icm_pkg::M_STOP) ##[1:300] m_stop;
  endproperty
  a_stop: assert property (p_stop) else $error("no stop");
  property p_gc;
    @(posedge core_clk_i) disable iff (rst_i)
    (load_req && gc_sent && head_dir) |=> raw[`ICM_EV_ABORT];
  endproperty
  a_gc: assert property (p_gc) else $error("gc abort lost");
  property p_rdent;
    @(posedge core_clk_i) disable iff (rst_i)
    (load_req && head_dir && !gc_sent && en && !slave)
      |=> (sh[8:1] == 8'hff);
  endproperty
  a_rdent: assert property (p_rdent) else $error("read sent data");
  property p_rdata;
    @(posedge core_clk_i) disable iff (rst_i)
    (rd_i && addr_i == `ICM_OFS_DATA && !rx_empty)
      |=> (rdata_o[7:0] == $past(rx_dout));
  endproperty
  a_rdata: assert property (p_rdata) else $error("bad rx byte");
  property p_sabort;
    @(posedge core_clk_i) disable iff (rst_i)
    (sst == icm_pkg::S_TXW && en && slave && !start_c && !stop_c &&
     !tx_empty && head_dir) |=> raw[`ICM_EV_ABORT];
  endproperty
  a_sabort: assert property (p_sabort) else $error("slave abort");
endmodule

/* verif/icm_tgt.sv */
// Behavioural I2C target for the controller bench
// Assumes the bench resolves pulled-up wires from all enables
`timescale 1ns/1ps
module icm_tgt (
  // Bus wires
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_oe_o,
  output logic scl_oe_o,
  // Bench side
  input wire logic stretch_i,
  input wire logic [7:0] rd_byte_i,
  output logic [7:0] addr_o,
  output logic [7:0] last_o,
  output int nbytes_o
);
  int cnt = 0;
  logic first = 1'b0;
  logic [7:0] sh = 8'h00;
  logic [7:0] tx = 8'h00;
  initial begin
    sda_oe_o = 1'b0;
    scl_oe_o = 1'b0;
    nbytes_o = 0;
    addr_o = 8'h00;
  end
  // Start or repeated start opens a new address byte
  always @(negedge sda_i) if (scl_i === 1'b1) begin
    cnt = 0;
    first = 1'b1;
  end
  // Bits are taken on the rising clock
  always @(posedge scl_i) begin
    sh = {sh[6:0], sda_i};
    cnt++;
  end
  // Changes only while the clock is low; released sda floats high
  always @(negedge scl_i) begin
    if (cnt == 8 && first) begin
      addr_o = sh;
      first = 1'b0;
      sda_oe_o = 1'b1;
    end else if (cnt == 8) begin
      last_o = sh;
      if (!addr_o[0]) nbytes_o++;
      sda_oe_o = ~addr_o[0]; // Released so the master acks reads
    end else if (cnt == 9) begin
      cnt = 0;
      tx = rd_byte_i;
      sda_oe_o = addr_o[0] & ~sh[0] & ~tx[7]; // A nack ends sending
      if (stretch_i) begin
        scl_oe_o = 1'b1; // Slow answer: clock held low
        #3000 scl_oe_o = 1'b0;
      end
    end else if (addr_o[0] && !first && cnt > 0)
      sda_oe_o = ~tx[7 - cnt];
  end
endmodule

/* verif/i2c_master_cmd_and_ss_high_count_test.sv */
// Self-checking bench for the I2C controller command path
// Assumes the behavioural target model on a pulled-up bus
`timescale 1ns/1ps
module i2c_master_cmd_and_ss_high_count_test;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [31:0] rdata_o, d, hc;
  logic scl_o, scl_oe_o, sda_o, sda_oe_o, irq_o, t_oe, t_scl, s;
  logic stretch = 1'b0;
  logic [7:0] rbyte = 8'h00, taddr, tlast, b;
  logic [6:0] ta;
  int tn, n, ns, i, j, bad_count = 0, cmp_count = 0, stops = 0;
  realtime tstop = 0;
  // Open-drain wires with pull-ups
  wire scl = ~(scl_oe_o | t_scl);
  wire sda = ~(sda_oe_o | t_oe);
  initial forever #50 core_clk_i = ~core_clk_i;
  icm_ctrl uut (.core_clk_i(core_clk_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .scl_i(scl), .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_i(sda),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o), .irq_o(irq_o));
  icm_tgt tgt (.scl_i(scl), .sda_i(sda), .sda_oe_o(t_oe),
    .scl_oe_o(t_scl), .stretch_i(stretch), .rd_byte_i(rbyte),
    .addr_o(taddr), .last_o(tlast), .nbytes_o(tn));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge core_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
  endtask
  // Waits for a stop count, then reads and clears the event bits
  task automatic wstop(input int k, input logic [31:0] m);
    for (int w = 0; w < 30000 && stops < k; w++) @(posedge core_clk_i);
    repeat (4) @(posedge core_clk_i);
    chk({31'h0, irq_o}, 32'h1);
    rd(8'h34, d);
    chk(d & m, m);
    chk({31'h0, irq_o}, 32'h0);
  endtask
  task automatic end_sim;
    $display("Comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Stop marks; the next start must wait out the idle count
  always @(posedge sda) if (scl === 1'b1 && !rst_i) begin
    stops++;
    tstop = $realtime;
  end
  always @(negedge sda) if (scl === 1'b1 && tstop > 0) begin
    chk(32'($realtime - tstop >= (hc + 10) * 100.0), 32'h1);
    chk(32'($realtime - tstop <= (3 * hc + 40) * 100.0), 32'h1);
    tstop = 0;
  end
  initial begin
    #5000000;
    bad_count++;
    end_sim;
  end
  initial begin
    void'($urandom(32'haaa27fb5));
    stretch = 1'($urandom_range(0, 1));
    repeat (6) @(posedge core_clk_i);
    rst_i <= 1'b0;
    rd(8'h14, d);
    chk(d, 32'h28);
    rd(8'h7c, d);
    chk(d, 32'h0);
    wr(8'h14, 32'h3);
    rd(8'h14, d);
    chk(d, 32'h6);
    hc = 32'($urandom_range(6, 20)); // Whole word, far below 65525
    wr(8'h14, hc); // Programmed before any transfer
    rd(8'h14, d);
    chk(d, hc);
    ta = 7'($urandom_range(8, 119));
    wr(8'h04, {25'h0, ta});
    wr(8'h30, 32'h240);
    wr(8'h6c, 32'h1);
    wr(8'h14, 32'h30);
    rd(8'h14, d);
    chk(d, hc);
    // Random write bursts, stop flags random, last one set
    repeat (2) begin
      n = $urandom_range(1, 3);
      ns = 0;
      stops = 0;
      j = tn;
      for (i = 0; i < n; i++) begin
        b = 8'($urandom);
        s = (i == n - 1) | 1'($urandom_range(0, 1));
        ns += int'(s);
        wr(8'h10, {21'h0, 1'b0, s, 1'b0, b});
      end
      wstop(ns, 32'h200);
      chk(32'(stops), 32'(ns));
      chk(32'(tn - j), 32'(n));
      chk({24'h0, tlast}, {24'h0, b});
      chk({24'h0, taddr}, {24'h0, ta, 1'b0});
    end
    // One read entry for the single expected byte
    rbyte = 8'($urandom);
    stops = 0;
    j = tn;
    wr(8'h10, {21'h0, 1'b0, 1'b1, 1'b1, 8'hff});
    wstop(1, 32'h200);
    chk(32'(tn), 32'(j));
    chk({24'h0, taddr}, {24'h0, ta, 1'b1});
    rd(8'h70, d);
    chk(d & 32'h8, 32'h8);
    rd(8'h10, d);
    chk(d, {24'h0, rbyte});
    rd(8'h70, d);
    chk(d & 32'h8, 32'h0);
    // Empty queue without stop stalls with the clock low
    stops = 0;
    j = tn;
    wr(8'h10, {22'h0, 2'b00, 8'h5a});
    for (i = 0; i < 30000 && tn == j; i++) @(posedge core_clk_i);
    repeat (100) @(posedge core_clk_i);
    chk({31'h0, scl}, 32'h0);
    chk(32'(stops), 32'h0);
    wr(8'h10, {22'h0, 2'b10, 8'h3c});
    wstop(1, 32'h200);
    chk(32'(tn - j), 32'h2);
    // Restart flag and direction change give repeated starts, one stop
    wr(8'h6c, 32'h0);
    wr(8'h00, 32'h20);
    wr(8'h6c, 32'h1);
    stops = 0;
    j = tn;
    wr(8'h10, 32'h00000081);
    wr(8'h10, 32'h00000442); // Same direction, restart flag set
    wr(8'h10, 32'h00000300);
    wstop(1, 32'h204);
    chk(32'(stops), 32'h1);
    chk(32'(tn - j), 32'h2);
    chk({24'h0, taddr}, {24'h0, ta, 1'b1});
    rd(8'h10, d);
    chk(d, {24'h0, rbyte});
    // Read entry after a general call aborts; repeated starts still on
    wr(8'h6c, 32'h0);
    wr(8'h04, 32'hc00);
    wr(8'h6c, 32'h1);
    stops = 0;
    wr(8'h10, {22'h0, 2'b00, 8'h06});
    wr(8'h10, {22'h0, 2'b11, 8'h00});
    wstop(1, 32'h40);
    chk({30'h0, scl_o, sda_o}, 32'h0);
    end_sim;
  end
endmodule
